/* rtl/tlc_defs.svh */
/*
 Constants of the T1 loop code block: register indices, field positions,
 length codes, frame size and detector timing.
 Assumes it is included once per compile unit ahead of the package.
*/
`ifndef TLC_DEFS_SVH
`define TLC_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices within one framer, byte address is four times these
`define TLC_IDX_RIBCC 9'h082
`define TLC_IDX_LBCTL 9'h083
`define TLC_IDX_LS 9'h092
`define TLC_IDX_SPCD1 9'h09C
`define TLC_IDX_SPCD2 9'h09D
`define TLC_IDX_SPCC 9'h09E
`define TLC_IDX_IM 9'h0A2
`define TLC_IDX_UPCD1 9'h0AC
`define TLC_IDX_UPCD2 9'h0AD
`define TLC_IDX_DNCD1 9'h0AE
`define TLC_IDX_DNCD2 9'h0AF
`define TLC_IDX_RT 9'h0B2
`define TLC_IDX_MODE 9'h0FE
`define TLC_IDX_TC3 9'h183
`define TLC_IDX_TC4 9'h186
`define TLC_IDX_TCD1 9'h1AC
`define TLC_IDX_TCD2 9'h1AD

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define TLC_TXEN_BIT 0
`define TLC_TC_LSB 0
`define TLC_NOFBIT_BIT 2
`define TLC_LB_FRAMER 0
`define TLC_LB_PAYLOAD 1
`define TLC_LB_REMOTE 2
`define TLC_MODE_T1_BIT 0
`define TLC_UP_LEN_LSB 3
`define TLC_DN_LEN_LSB 0
`define TLC_SP_LEN_LSB 0
`define TLC_LCLR_LSB 4
`define TLC_RST_VAL 8'h00

////////////////////////////////////////////////////////////////////////////////
// Length codes, last pattern index for each
`define TLC_TXLEN_5 2'h0
`define TLC_TXLEN_6 2'h1
`define TLC_TXLEN_7 2'h2
`define TLC_LAST5 4'h4
`define TLC_LAST6 4'h5
`define TLC_LAST7 4'h6
`define TLC_LAST16 4'hF
`define TLC_RXLEN_16 3'h7

////////////////////////////////////////////////////////////////////////////////
// Frame and detector timing
`define TLC_FRAME_LAST 8'hC0
`define TLC_INTEG_MS 48
`define TLC_CLK_KHZ 200000
`define TLC_SCORE_BAD 5'h04
`define TLC_SCORE_SLIP 5'h10
`define TLC_ERR_SHIFT 3

`endif

/* rtl/tlc_pkg.sv */
/*
 Types of the T1 loop code block.
 Assumes tlc_defs.svh holds the numeric constants.
*/
package tlc_pkg;
   // Detector setup: length code and 16-bit pattern, first byte high
   typedef struct packed {
      logic [2:0] len;
      logic [15:0] pat;
   } tlc_det_cfg_t;
endpackage

/* rtl/tlc_top.sv */
/*
 One framer port's T1 in-band loop code generator, three loop code
 detectors, latched status and the framer, payload and remote loopbacks,
 with a classic Wishbone register slave.
 Assumes bit_en_i is a one-cycle pulse per line bit on clk_i, that the
 transmit and receive frames share one alignment, and that rx_line_i
 comes straight from a pin.
*/
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "tlc_defs.svh"

module tlc_top
   import tlc_pkg::*;
#(
   parameter logic [1:0] FRAMER_SEL = 2'h0,
   parameter int INTEG_CYCLES = `TLC_INTEG_MS * `TLC_CLK_KHZ,
   parameter int CNT_W = 24,
   parameter int BIT_W = 18
) (
   input wire logic clk_i, // System clock, 200 MHz
   input wire logic rst_i, // Synchronous reset, high
   input wire logic wb_cyc_i, // Bus cycle
   input wire logic wb_stb_i, // Bus strobe
   input wire logic wb_we_i, // Write enable
   input wire logic [31:0] wb_adr_i, // Byte address
   input wire logic [31:0] wb_dat_i, // Write data
   input wire logic [3:0] wb_sel_i, // Byte selects
   output logic [31:0] wb_dat_o, // Read data
   output logic wb_ack_o, // Acknowledge
   input wire logic bit_en_i, // One pulse per line bit
   input wire logic tx_data_i, // Transmit payload bit
   input wire logic tx_fbit_i, // Framing bit from formatter
   input wire logic rx_line_i, // Received line bit, pin
   output logic tx_line_o, // Transmit line bit
   output logic rx_data_o, // Bit entering the receiver
   output logic irq_o // Masked latched status
);

   localparam logic [CNT_W-1:0] INTEG_LAST = CNT_W'(INTEG_CYCLES - 1);

   function automatic logic [3:0] step(input logic [3:0] p, input logic [3:0] l);
      step = (p == l) ? 4'h0 : p + 4'h1;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave
   logic ack_q;
   logic [31:0] dat_q;
   logic [7:0] rdata;
   logic req;
   logic hit;
   logic wr;
   logic [10:0] idx;
   logic [8:0] lidx;

   assign req = wb_cyc_i & wb_stb_i & ~ack_q;
   assign idx = wb_adr_i[12:2];
   assign lidx = idx[8:0];
   assign hit = (wb_adr_i[31:13] == 19'h0) & (idx[10:9] == FRAMER_SEL);
   assign wr = req & wb_we_i & wb_sel_i[0] & hit;

   logic [7:0] rx_inband_code_length_ctrl_q;
   logic [7:0] rx_loopback_ctrl_q;
   logic [7:0] rx_latched_status_three_q;
   logic [7:0] rx_spare_code_def_one_q;
   logic [7:0] rx_spare_code_def_two_q;
   logic [7:0] rx_spare_code_ctrl_q;
   logic [7:0] rx_interrupt_mask_three_q;
   logic [7:0] rx_up_code_def_one_q;
   logic [7:0] rx_up_code_def_two_q;
   logic [7:0] rx_down_code_def_one_q;
   logic [7:0] rx_down_code_def_two_q;
   logic [7:0] line_mode_ctrl_q;
   logic [7:0] tx_control_three_q;
   logic [7:0] tx_control_four_q;
   logic [7:0] tx_code_def_one_q;
   logic [7:0] tx_code_def_two_q;
   logic [2:0] det_rt;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_inband_code_length_ctrl_q <= `TLC_RST_VAL;
         rx_loopback_ctrl_q <= `TLC_RST_VAL;
         rx_spare_code_def_one_q <= `TLC_RST_VAL;
         rx_spare_code_def_two_q <= `TLC_RST_VAL;
         rx_spare_code_ctrl_q <= `TLC_RST_VAL;
         rx_interrupt_mask_three_q <= `TLC_RST_VAL;
         rx_up_code_def_one_q <= `TLC_RST_VAL;
         rx_up_code_def_two_q <= `TLC_RST_VAL;
         rx_down_code_def_one_q <= `TLC_RST_VAL;
         rx_down_code_def_two_q <= `TLC_RST_VAL;
         line_mode_ctrl_q <= `TLC_RST_VAL;
         tx_control_three_q <= `TLC_RST_VAL;
         tx_control_four_q <= `TLC_RST_VAL;
         tx_code_def_one_q <= `TLC_RST_VAL;
         tx_code_def_two_q <= `TLC_RST_VAL;
      end else if (wr) begin
         case (lidx)
            `TLC_IDX_RIBCC: rx_inband_code_length_ctrl_q <= wb_dat_i[7:0];
            `TLC_IDX_LBCTL: rx_loopback_ctrl_q <= wb_dat_i[7:0];
            `TLC_IDX_SPCD1: rx_spare_code_def_one_q <= wb_dat_i[7:0];
            `TLC_IDX_SPCD2: rx_spare_code_def_two_q <= wb_dat_i[7:0];
            `TLC_IDX_SPCC: rx_spare_code_ctrl_q <= wb_dat_i[7:0];
            `TLC_IDX_IM: rx_interrupt_mask_three_q <= wb_dat_i[7:0];
            `TLC_IDX_UPCD1: rx_up_code_def_one_q <= wb_dat_i[7:0];
            `TLC_IDX_UPCD2: rx_up_code_def_two_q <= wb_dat_i[7:0];
            `TLC_IDX_DNCD1: rx_down_code_def_one_q <= wb_dat_i[7:0];
            `TLC_IDX_DNCD2: rx_down_code_def_two_q <= wb_dat_i[7:0];
            `TLC_IDX_MODE: line_mode_ctrl_q <= wb_dat_i[7:0];
            `TLC_IDX_TC3: tx_control_three_q <= wb_dat_i[7:0];
            `TLC_IDX_TC4: tx_control_four_q <= wb_dat_i[7:0];
            `TLC_IDX_TCD1: tx_code_def_one_q <= wb_dat_i[7:0];
            `TLC_IDX_TCD2: tx_code_def_two_q <= wb_dat_i[7:0];
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      rdata = 8'h00;
      if (hit) begin
         case (lidx)
            `TLC_IDX_RIBCC: rdata = rx_inband_code_length_ctrl_q;
            `TLC_IDX_LBCTL: rdata = rx_loopback_ctrl_q;
            `TLC_IDX_LS: rdata = rx_latched_status_three_q;
            `TLC_IDX_SPCD1: rdata = rx_spare_code_def_one_q;
            `TLC_IDX_SPCD2: rdata = rx_spare_code_def_two_q;
            `TLC_IDX_SPCC: rdata = rx_spare_code_ctrl_q;
            `TLC_IDX_IM: rdata = rx_interrupt_mask_three_q;
            `TLC_IDX_UPCD1: rdata = rx_up_code_def_one_q;
            `TLC_IDX_UPCD2: rdata = rx_up_code_def_two_q;
            `TLC_IDX_DNCD1: rdata = rx_down_code_def_one_q;
            `TLC_IDX_DNCD2: rdata = rx_down_code_def_two_q;
            `TLC_IDX_RT: rdata = {5'h00, det_rt};
            `TLC_IDX_MODE: rdata = line_mode_ctrl_q;
            `TLC_IDX_TC3: rdata = tx_control_three_q;
            `TLC_IDX_TC4: rdata = tx_control_four_q;
            `TLC_IDX_TCD1: rdata = tx_code_def_one_q;
            `TLC_IDX_TCD2: rdata = tx_code_def_two_q;
            default: rdata = 8'h00;
         endcase
      end
   end

   // Unmapped addresses still answer, with zero, so the master never hangs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= req;
         if (req) begin
            dat_q <= {24'h00_0000, rdata};
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   ////////////////////////////////////////////////////////////////////////////
   // Mode and control decode
   logic t1_mode;
   logic txen;
   logic no_fbit;
   logic lb_framer;
   logic lb_payload;
   logic lb_remote;
   logic [1:0] tx_len;

   assign t1_mode = line_mode_ctrl_q[`TLC_MODE_T1_BIT];
   assign txen = tx_control_three_q[`TLC_TXEN_BIT] & t1_mode;
   assign no_fbit = tx_control_four_q[`TLC_NOFBIT_BIT];
   assign tx_len = tx_control_four_q[`TLC_TC_LSB +: 2];
   assign lb_framer = rx_loopback_ctrl_q[`TLC_LB_FRAMER];
   assign lb_payload = rx_loopback_ctrl_q[`TLC_LB_PAYLOAD];
   assign lb_remote = rx_loopback_ctrl_q[`TLC_LB_REMOTE];

   ////////////////////////////////////////////////////////////////////////////
   // Receive pin synchroniser, a change counts once stages two and three agree
   logic rx_s1_q;
   logic rx_s2_q;
   logic rx_s3_q;
   logic rx_level_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_s1_q <= 1'b0;
         rx_s2_q <= 1'b0;
         rx_s3_q <= 1'b0;
         rx_level_q <= 1'b0;
      end else begin
         rx_s1_q <= rx_line_i;
         rx_s2_q <= rx_s1_q;
         rx_s3_q <= rx_s2_q;
         if (rx_s2_q == rx_s3_q) begin
            rx_level_q <= rx_s3_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame position, shared by both directions
   logic [7:0] frame_q;
   logic fpos;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_q <= 8'h00;
      end else if (bit_en_i) begin
         frame_q <= (frame_q == `TLC_FRAME_LAST) ? 8'h00 : frame_q + 8'h01;
      end
   end

   assign fpos = (frame_q == 8'h00);

   ////////////////////////////////////////////////////////////////////////////
   // Loop code generator
   logic [3:0] tx_ptr_q;
   logic [3:0] tx_last;
   logic [15:0] tx_pat;
   logic gen_bit;
   logic tx_next;
   logic det_in;

   // length decode, 5, 6 or 7 bits of the first byte, else all 16
   always_comb begin
      case (tx_len)
         `TLC_TXLEN_5: tx_last = `TLC_LAST5;
         `TLC_TXLEN_6: tx_last = `TLC_LAST6;
         `TLC_TXLEN_7: tx_last = `TLC_LAST7;
         default: tx_last = `TLC_LAST16;
      endcase
   end

   assign tx_pat = (tx_last == `TLC_LAST16) ?
      {tx_code_def_one_q, tx_code_def_two_q} : {tx_code_def_one_q, 8'h00};
   assign gen_bit = tx_pat[4'hF - tx_ptr_q];

   // repeat while enabled
   // Pointer keeps running under the framing bit, so the F-bit overwrites
   always_ff @(posedge clk_i) begin
      if (rst_i || !txen) begin
         tx_ptr_q <= 4'h0;
      end else if (bit_en_i) begin
         tx_ptr_q <= step(tx_ptr_q, tx_last);
      end
   end

   always_comb begin
      tx_next = txen ? gen_bit : tx_data_i;
      if (lb_payload && !fpos) begin
         tx_next = rx_level_q;
      end
      if (fpos && !no_fbit) begin
         tx_next = tx_fbit_i;
      end
      if (lb_remote) begin
         tx_next = rx_level_q;
      end
   end

   assign det_in = lb_framer ? tx_next : rx_level_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_line_o <= 1'b0;
         rx_data_o <= 1'b0;
      end else if (bit_en_i) begin
         tx_line_o <= tx_next;
         rx_data_o <= det_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Three detectors: up, down, spare
   tlc_det_cfg_t det_cfg [3];
   logic [2:0] det_restart;

   assign det_cfg[0] = {rx_inband_code_length_ctrl_q[`TLC_UP_LEN_LSB +: 3],
      rx_up_code_def_one_q, rx_up_code_def_two_q};
   assign det_cfg[1] = {rx_inband_code_length_ctrl_q[`TLC_DN_LEN_LSB +: 3],
      rx_down_code_def_one_q, rx_down_code_def_two_q};
   assign det_cfg[2] = {rx_spare_code_ctrl_q[`TLC_SP_LEN_LSB +: 3],
      rx_spare_code_def_one_q, rx_spare_code_def_two_q};

   assign det_restart[0] = wr & (lidx == `TLC_IDX_UPCD1);
   assign det_restart[1] = wr & (lidx == `TLC_IDX_DNCD1);
   assign det_restart[2] = wr & (lidx == `TLC_IDX_SPCD1);

   for (genvar g = 0; g < 3; g++) begin : g_det
      logic [3:0] ptr_q;
      logic [4:0] score_q;
      logic [CNT_W-1:0] cyc_q;
      logic [BIT_W-1:0] bits_q;
      logic [BIT_W-1:0] errs_q;
      logic rt_q;
      logic is16;
      logic [3:0] last;
      logic [15:0] pat;
      logic match;
      logic slip;
      logic period_end;
      logic [3:0] p1;
      logic [3:0] p2;

      assign is16 = (det_cfg[g].len == `TLC_RXLEN_16);
      assign last = is16 ? `TLC_LAST16 : {1'b0, det_cfg[g].len};
      assign pat = is16 ? det_cfg[g].pat : {det_cfg[g].pat[15:8], 8'h00};
      assign match = (pat[4'hF - ptr_q] == det_in);
      assign slip = !match && ((score_q + `TLC_SCORE_BAD) >= `TLC_SCORE_SLIP);
      assign p1 = step(ptr_q, last);
      assign p2 = step(p1, last);
      assign period_end = (cyc_q == INTEG_LAST);

      // Phase tracking: a burst of misses skips one pattern position
      always_ff @(posedge clk_i) begin
         if (rst_i || !t1_mode || det_restart[g]) begin
            ptr_q <= 4'h0;
            score_q <= 5'h00;
         end else if (bit_en_i) begin
            ptr_q <= slip ? p2 : p1;
            if (slip) begin
               score_q <= 5'h00;
            end else if (match) begin
               score_q <= (score_q == 5'h00) ? 5'h00 : score_q - 5'h01;
            end else begin
               score_q <= score_q + `TLC_SCORE_BAD;
            end
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i || !t1_mode || det_restart[g] || period_end) begin
            cyc_q <= '0;
            bits_q <= '0;
            errs_q <= '0;
         end else begin
            cyc_q <= cyc_q + 1'b1;
            if (bit_en_i) begin
               bits_q <= bits_q + 1'b1;
               errs_q <= errs_q + BIT_W'(!match);
            end
         end
      end

      // pass with under one miss in eight
      always_ff @(posedge clk_i) begin
         if (rst_i || !t1_mode) begin
            rt_q <= 1'b0;
         end else if (period_end) begin
            rt_q <= (bits_q != '0) && (errs_q < (bits_q >> `TLC_ERR_SHIFT));
         end
      end

      assign det_rt[g] = rt_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Latched status and interrupt
   logic [2:0] rt_prev_q;
   logic [7:0] lat_evt;
   logic [7:0] lat_clr;

   // set on rise, clear bit on fall
   assign lat_evt = {1'b0, det_rt & ~rt_prev_q, 1'b0, ~det_rt & rt_prev_q} <<
      `TLC_LCLR_LSB | {5'h00, det_rt & ~rt_prev_q};
   assign lat_clr = (wr && lidx == `TLC_IDX_LS) ? wb_dat_i[7:0] : 8'h00;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rt_prev_q <= 3'h0;
         rx_latched_status_three_q <= `TLC_RST_VAL;
         irq_o <= 1'b0;
      end else begin
         rt_prev_q <= det_rt;
         // New events win over a write-one clear in the same cycle
         rx_latched_status_three_q <= (rx_latched_status_three_q & ~lat_clr) | lat_evt;
         irq_o <= |(rx_latched_status_three_q & rx_interrupt_mask_three_q);
      end
   end

endmodule

`default_nettype wire

/* verif/tlc_top_chk.sv */
/* Port-level assertions for tlc_top.
   Assumes one clk_i domain and the framer set by FRAMER_SEL. */
`timescale 1ns/1ps
`default_nettype none
`include "tlc_defs.svh"
module tlc_chk #(
   parameter logic [1:0] FRAMER_SEL = 2'h0
) (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic wb_cyc_i, // Cycle
   input wire logic wb_stb_i, // Strobe
   input wire logic wb_we_i, // Write
   input wire logic [31:0] wb_adr_i, // Address
   input wire logic [31:0] wb_dat_i, // Write data
   input wire logic [3:0] wb_sel_i, // Selects
   input wire logic [31:0] wb_dat_o, // Read data
   input wire logic wb_ack_o, // Ack
   input wire logic bit_en_i, // Bit strobe
   input wire logic tx_fbit_i, // Framing bit
   input wire logic tx_line_o, // Line out
   input wire logic rx_data_o, // Receiver bit
   input wire logic irq_o // Interrupt
);
   logic take;
   logic wr;
   logic [7:0] mask_q;
   logic [2:0] lb_q;
   logic nof_q;
   logic [7:0] pos_q;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = take && wb_we_i && wb_sel_i[0];
   function automatic logic at(input logic [31:0] a, input logic [8:0] idx);
      return a == {19'h0, FRAMER_SEL, idx, 2'h0};
   endfunction
   ////////////////////////////////////////////////////////////
   // Shadow of the few registers the checks depend on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_q <= 8'h00;
         lb_q <= 3'h0;
         nof_q <= 1'b0;
      end else if (wr) begin
         if (at(wb_adr_i, `TLC_IDX_IM)) begin
            mask_q <= wb_dat_i[7:0];
         end
         if (at(wb_adr_i, `TLC_IDX_LBCTL)) begin
            lb_q <= wb_dat_i[2:0];
         end
         if (at(wb_adr_i, `TLC_IDX_TC4)) begin
            nof_q <= wb_dat_i[`TLC_NOFBIT_BIT];
         end
      end
   end
   // Frame position, zero is the framing bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos_q <= 8'h00;
      end else if (bit_en_i) begin
         pos_q <= (pos_q == `TLC_FRAME_LAST) ? 8'h00 : pos_q + 8'h01;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_resp_a: assert property (take |=> wb_ack_o)
      else $error("ack missing after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(take))
      else $error("ack without request");
   unmap_zero_a: assert property (wb_ack_o &&
      $past(!wb_we_i && wb_adr_i[31:11] != {19'h0, FRAMER_SEL}) |-> wb_dat_o == 32'h0)
      else $error("foreign address read not zero");
   rd_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
      else $error("read data moved without ack");
   tx_hold_a: assert property (!$past(bit_en_i) |-> $stable(tx_line_o))
      else $error("line out moved between bits");
   rx_hold_a: assert property (!$past(bit_en_i) |-> $stable(rx_data_o))
      else $error("receiver bit moved between bits");
   fbit_ins_a: assert property (bit_en_i && pos_q == 8'h00 && !nof_q && !lb_q[2]
      |=> tx_line_o == $past(tx_fbit_i))
      else $error("framing bit not inserted");
   irq_mask_a: assert property (irq_o |-> $past(mask_q) != 8'h00)
      else $error("interrupt with all masked");
   pay_loop_a: assert property (bit_en_i && pos_q != 8'h00 && lb_q == 3'h2
      |=> tx_line_o == rx_data_o)
      else $error("payload not looped back");
   irq_c: cover property ($rose(irq_o));
   fbit_c: cover property (bit_en_i && pos_q == 8'h00 && !nof_q);
   unmap_c: cover property (wb_ack_o && $past(wb_adr_i[31:11] != {19'h0, FRAMER_SEL}));
endmodule
`default_nettype wire

/* verif/tlc_far.sv */
/* Far-end T1 equipment sending a repeating code toward the receiver.
   Assumes bit_en_i pulses once per line bit. */
`timescale 1ns/1ps
`default_nettype none
module tlc_far (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic bit_en_i, // Line bit strobe
   input wire logic [15:0] pat_i, // Code, first bit at msb
   input wire logic [3:0] last_i, // Last code index
   input wire logic frm_i, // Overwrite framing positions
   input wire logic err_i, // One error per 100 bits
   output logic line_o // Line bit
);
   logic [3:0] idx_q;
   logic [7:0] pos_q;
   logic [6:0] err_q;
   logic fb_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idx_q <= 4'h0;
         pos_q <= 8'h00;
         err_q <= 7'h00;
         fb_q <= 1'b0;
         line_o <= 1'b0;
      end else if (bit_en_i) begin
         idx_q <= (idx_q >= last_i) ? 4'h0 : idx_q + 4'h1;
         pos_q <= (pos_q == 8'hC0) ? 8'h00 : pos_q + 8'h01;
         err_q <= (err_q == 7'h63) ? 7'h00 : err_q + 7'h01;
         if (frm_i && pos_q == 8'h00) begin
            // framing bit overwrites a code bit
            fb_q <= !fb_q;
            line_o <= fb_q;
         end else begin
            // errors at one in 100 bits, well under the tolerated one in eight
            line_o <= pat_i[4'hF - idx_q] ^ (err_i && err_q == 7'h00);
         end
      end
   end
endmodule
`default_nettype wire

/* verif/test_t1_loop_code_gen_detect.sv */
/* Self-checking bench for tlc_top with a far-end model.
   Assumes a short integration window so detection fits the run. */
`timescale 1ns/1ps
`default_nettype none
`include "tlc_defs.svh"
`define CHK(n, e, g) \
   begin \
      tests_run++; \
      if ((g) !== (e)) begin \
         error_cnt++; \
         $display("ERROR %s expected %h seen %h", n, e, g); \
      end \
   end
module test_t1_loop_code_gen_detect;
   logic clk_i, rst_i, cyc, stb, we, ack, bit_en, tx_data, tx_fbit, rx_line;
   logic tx_line, rx_data, irq, ffrm, ferr;
   logic [31:0] adr, dat, dat_o, e;
   logic [31:0] lf = 32'h17495145;
   logic [31:0] lt = 32'h17495145;
   logic [3:0] sel, flast;
   logic [3:0] wsel = 4'hF;
   logic [1:0] fr = 2'h0;
   logic [15:0] fpat;
   logic [31:0] exp_q[$];
   int error_cnt = 0;
   int tests_run = 0;
   int lens[4] = '{5, 6, 7, 16};
   logic [8:0] dreg[3] = '{`TLC_IDX_UPCD1, `TLC_IDX_DNCD1, `TLC_IDX_SPCD1};
   logic [8:0] regs[17] = '{`TLC_IDX_UPCD1, `TLC_IDX_UPCD2, `TLC_IDX_DNCD1,
      `TLC_IDX_DNCD2, `TLC_IDX_SPCD1, `TLC_IDX_SPCD2, `TLC_IDX_TCD1, `TLC_IDX_TCD2,
      `TLC_IDX_RIBCC, `TLC_IDX_LBCTL, `TLC_IDX_LS, `TLC_IDX_SPCC, `TLC_IDX_IM,
      `TLC_IDX_RT, `TLC_IDX_MODE, `TLC_IDX_TC3, `TLC_IDX_TC4};

   tlc_top #(.INTEG_CYCLES(2000)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .bit_en_i(bit_en), .tx_data_i(tx_data),
      .tx_fbit_i(tx_fbit), .rx_line_i(rx_line), .tx_line_o(tx_line),
      .rx_data_o(rx_data), .irq_o(irq));
   tlc_far far (.clk_i(clk_i), .rst_i(rst_i), .bit_en_i(bit_en), .pat_i(fpat),
      .last_i(flast), .frm_i(ffrm), .err_i(ferr), .line_o(rx_line));

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // True when the 32 bits repeat some rotation of the code
   function automatic logic rot(input logic [31:0] s, input logic [15:0] p, input int l);
      logic m;
      rot = 1'b0;
      for (int r = 0; r < l; r++) begin
         m = 1'b1;
         for (int k = 0; k < 32; k++) begin
            if (s[31 - k] !== p[15 - (r + k) % l]) m = 1'b0;
         end
         if (m) rot = 1'b1;
      end
   endfunction
   task automatic summarize();
      $display("Checks %0d, errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wb(input logic w, input logic [8:0] i, input logic [7:0] d,
      output logic [7:0] r);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {19'h0, fr, i, 2'h0};
      dat <= {24'h0, d};
      sel <= wsel;
      do @(posedge clk_i); while (ack !== 1'b1);
      r = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [8:0] i, input logic [7:0] d);
      logic [7:0] r;
      wb(1'b1, i, d, r);
   endtask
   task automatic rd(input logic [8:0] i, input logic [7:0] x);
      logic [7:0] r;
      exp_q.push_back({24'h0, x});
      wb(1'b0, i, 8'h00, r);
   endtask
   task automatic grab(output logic [31:0] s);
      repeat (40) @(posedge clk_i);
      for (int k = 0; k < 32; k++) begin
         do @(posedge clk_i); while (bit_en !== 1'b1);
         @(posedge clk_i);
         s = {s[30:0], tx_line};
      end
   endtask

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // Bit strobe every five clocks with random payload
   initial begin
      bit_en = 1'b0;
      tx_data = 1'b0;
      tx_fbit = 1'b0;
      forever begin
         repeat (4) @(posedge clk_i);
         bit_en <= !rst_i;
         tx_data <= lt[2];
         tx_fbit <= lt[3];
         lt = nxt(lt);
         @(posedge clk_i);
         bit_en <= 1'b0;
      end
   end
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         `CHK("read data", e, dat_o)
      end
   end
   initial begin
      repeat (90000) @(posedge clk_i);
      error_cnt++;
      summarize();
   end

   initial begin
      logic [7:0] v;
      logic [15:0] p;
      logic [31:0] s;
      int n;
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 32'h0;
      dat = 32'h0;
      sel = 4'hF;
      fpat = 16'hAAAA;
      flast = 4'hF;
      ffrm = 1'b0;
      ferr = 1'b0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (regs[k]) rd(regs[k], 8'h00);
      for (int k = 0; k < 8; k++) begin
         v = lf[7:0];
         lf = nxt(lf);
         wr(regs[k], v);
         rd(regs[k], v);
         wr(regs[k], 8'h00);
      end
      wr(`TLC_IDX_RT, 8'hFF);
      rd(`TLC_IDX_RT, 8'h00);
      wr(`TLC_IDX_LS, 8'hFF);
      rd(`TLC_IDX_LS, 8'h00);
      wsel = 4'hE;
      wr(`TLC_IDX_TCD1, 8'h3C);
      wsel = 4'hF;
      fr = 2'h1;
      wr(`TLC_IDX_TCD1, 8'h5A);
      rd(`TLC_IDX_TCD1, 8'h00);
      fr = 2'h0;
      rd(`TLC_IDX_TCD1, 8'h00);
      rd(9'h1FF, 8'h00);
      ////////////////////////////////////////////////////////////
      // Generator at every length, framing suppressed
      wr(`TLC_IDX_MODE, 8'h01);
      wr(`TLC_IDX_TC3, 8'h01);
      for (int c = 0; c < 4; c++) begin
         p = lf[15:0];
         lf = nxt(lf);
         wr(`TLC_IDX_TCD1, p[15:8]);
         wr(`TLC_IDX_TCD2, p[7:0]);
         wr(`TLC_IDX_TC4, {5'h00, 1'b1, c[1:0]});
         grab(s);
         `CHK("tx pattern", 1'b1, rot(s, p, lens[c]))
      end
      p = lf[15:0];
      lf = nxt(lf);
      fpat <= p;
      wr(`TLC_IDX_TC3, 8'h00);
      wr(`TLC_IDX_LBCTL, 8'h04);
      grab(s);
      `CHK("remote loop", 1'b1, rot(s, p, 16))
      wr(`TLC_IDX_TC4, 8'h00);
      wr(`TLC_IDX_LBCTL, 8'h02);
      repeat (2000) @(posedge clk_i);
      ////////////////////////////////////////////////////////////
      // Up via own loop, down and spare from far end
      wr(`TLC_IDX_MODE, 8'h00);
      wr(`TLC_IDX_RIBCC, 8'h22);
      wr(`TLC_IDX_SPCC, 8'h07);
      wr(`TLC_IDX_IM, 8'h07);
      wr(`TLC_IDX_TCD1, 8'h80);
      ffrm <= 1'b1;
      ferr <= 1'b1;
      for (int d = 0; d < 3; d++) begin
         p = (d == 2) ? lf[15:0] : 16'h8000;
         fpat <= (d == 0) ? 16'hAAAA : p;
         flast <= (d == 1) ? 4'h2 : 4'hF;
         wr(`TLC_IDX_TC3, {7'h00, d == 0});
         wr(`TLC_IDX_LBCTL, {7'h00, d == 0});
         wr(dreg[d] + 9'h001, p[7:0]);
         wr(`TLC_IDX_MODE, 8'h01);
         repeat (4) begin
            wr(dreg[d], p[15:8]);
            repeat (1500) @(posedge clk_i);
         end
         rd(`TLC_IDX_RT, 8'h00);
         n = 0;
         do begin
            repeat (50) @(posedge clk_i);
            wb(1'b0, `TLC_IDX_RT, 8'h00, v);
            n++;
         end while (v !== (8'h01 << d) && n < 200);
         `CHK("realtime", 8'h01 << d, v)
         rd(`TLC_IDX_LS, 8'h01 << d);
         `CHK("irq set", 1'b1, irq)
         wr(`TLC_IDX_LS, 8'hFF);
         rd(`TLC_IDX_LS, 8'h00);
         `CHK("irq clear", 1'b0, irq)
         wr(`TLC_IDX_MODE, 8'h00);
         repeat (10) @(posedge clk_i);
         rd(`TLC_IDX_RT, 8'h00);
         rd(`TLC_IDX_LS, 8'h10 << d);
         `CHK("irq masked", 1'b0, irq)
         wr(`TLC_IDX_LS, 8'hFF);
      end
      `CHK("reads answered", 0, exp_q.size())
      summarize();
   end
endmodule
bind tlc_top tlc_chk #(.FRAMER_SEL(FRAMER_SEL)) chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .bit_en_i(bit_en_i), .tx_fbit_i(tx_fbit_i), .tx_line_o(tx_line_o),
   .rx_data_o(rx_data_o), .irq_o(irq_o));
`default_nettype wire
